// File: include/dpo_pkg.sv
package dpo_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam logic [15:0] PORT_TENTH = 16'h1000;
  localparam logic [15:0] PORT_COARSE = 16'h1100;
  localparam logic [15:0] CTRL_STOP = 16'h0003;
  localparam logic [15:0] FREQ_TENTH_MIN = 16'h0014;
  localparam logic [15:0] FREQ_TENTH_MAX = 16'hFFFF;
  localparam logic [15:0] FREQ_COARSE_MIN = 16'h0002;
  localparam logic [15:0] FREQ_COARSE_MAX = 16'h7D00;
  localparam logic [15:0] DUTY_MAX = 16'h03E8;
  // clock cycles per period at 0.1 Hz and at 1 Hz units
  localparam longint unsigned TENTH_CYC = 64'd10 * CLK_HZ;
  localparam longint unsigned UNIT_CYC = 64'd1 * CLK_HZ;
  // controller register offsets (byte addresses)
  localparam logic [3:0] REG_CMD_PORT = 4'h0;
  localparam logic [3:0] REG_CMD_FREQ = 4'h4;
  localparam logic [3:0] REG_CMD_DUTY = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'hC;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_EVENT = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h8;
  // REG_CTRL write bits
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT = 1;
  localparam int unsigned CTRL_RUN_BIT = 2;
  localparam int unsigned CTRL_IRQ_BIT = 3;
  localparam int unsigned CTRL_HOME_BIT = 4;
  // REG_CTRL write bits [9:8] load the interrupt mask
  localparam int unsigned CTRL_MASK_LSB = 8;
  // event bits
  localparam int unsigned EV_ERR_BIT = 0;
  localparam int unsigned EV_DONE_BIT = 1;
  localparam logic [1:0] EV_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
endpackage : dpo_pkg

// File: include/dpo_if.sv
interface dpo_if;
  import dpo_pkg::*;
  logic cmd_valid;
  logic cmd_stop;
  logic cmd_from_irq;
  logic [15:0] cmd_port;
  logic [15:0] cmd_freq;
  logic [15:0] cmd_duty;
  logic run_mode;
  logic cyclic_busy;
  logic home_seek_active;
  logic cmd_done;
  logic command_error_flag;
  logic running;
  modport device (
    input cmd_valid, cmd_stop, cmd_from_irq, cmd_port, cmd_freq,
    input cmd_duty, run_mode, cyclic_busy, home_seek_active,
    output cmd_done, command_error_flag, running
  );
  modport host (
    output cmd_valid, cmd_stop, cmd_from_irq, cmd_port, cmd_freq,
    output cmd_duty, run_mode, cyclic_busy, home_seek_active,
    input cmd_done, command_error_flag, running
  );
endinterface : dpo_if

// File: rtl/dpo_divider.sv
// sequential restoring divider: quo = num / den, rounded to nearest
module dpo_divider
  import dpo_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // request
  input wire logic start_i,
  input wire logic [47:0] num_i,
  input wire logic [31:0] den_i,
  // answer
  output logic busy_o,
  output logic [31:0] quo_o
);
  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [48:0] num;
    logic [32:0] rem;
    logic [32:0] den;
    logic [48:0] quo;
    logic [31:0] res;
  } dpo_div_s;
  dpo_div_s st_reg, st_next;

  always_comb begin
    logic [32:0] trial;
    trial = '0;
    st_next = st_reg;
    if (start_i && !st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.cnt = 6'd49;
      // add den/2 for round-to-nearest
      st_next.num = {1'b0, num_i} + {18'h0, den_i[31:1]};
      st_next.den = {1'b0, den_i};
      st_next.rem = '0;
      st_next.quo = '0;
    end else if (st_reg.busy) begin
      trial = {st_reg.rem[31:0], st_reg.num[48]};
      st_next.num = {st_reg.num[47:0], 1'b0};
      if (trial >= st_reg.den) begin
        st_next.rem = trial - st_reg.den;
        st_next.quo = {st_reg.quo[47:0], 1'b1};
      end else begin
        st_next.rem = trial;
        st_next.quo = {st_reg.quo[47:0], 1'b0};
      end
      st_next.cnt = st_reg.cnt - 6'd1;
      if (st_reg.cnt == 6'd1) begin
        st_next.busy = 1'b0;
        st_next.res = (st_next.quo[48:32] != '0) ? 32'hFFFFFFFF
                                                   : st_next.quo[31:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_o = st_reg.busy;
  assign quo_o = st_reg.res;
endmodule : dpo_divider

// File: rtl/dpo_output.sv
// Function
// - 1000 hex selects channel, 0.1 Hz units
// - 1100 hex selects channel, coarse units
// - tenth mode frequency 0014 to FFFF
// - coarse mode frequency 0002 to 7D00
// - duty 0000 to 03E8 tenths percent
// - high for duty fraction, else low
// - range error sets flag, command ignored
// - home seek on port sets flag
// - interrupt call during cyclic sets flag
// - each accepted non-stop command starts output, clears flag
// - running command updates duty only
// - frequency ignored while running
// - stop command 0003 halts output
// - leaving run mode stops output
// - controller issues single-cycle command trigger
module dpo_output
  import dpo_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // controller side
  dpo_if.device link,
  // waveform pin
  output logic pwm_o
);
  typedef enum {
    ST_IDLE, ST_DIV_PER, ST_DIV_HIGH, ST_RUN
  } dpo_state_e;
  typedef struct packed {
    dpo_state_e state;
    logic err;
    logic done;
    logic out;
    logic coarse;
    logic [15:0] freq;
    logic [15:0] duty;
    logic [31:0] period;
    logic [31:0] high;
    logic [31:0] high_pend;
    logic pend;
    logic kick;
    logic [31:0] cnt;
  } dpo_out_s;
  dpo_out_s st_reg, st_next;

  logic div_start;
  logic div_busy;
  logic [47:0] div_num;
  logic [31:0] div_den;
  logic [31:0] div_quo;
  logic port_ok, freq_ok, duty_ok, any_err;
  logic div_done;

  dpo_divider u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(div_start),
    .num_i(div_num),
    .den_i(div_den),
    .busy_o(div_busy),
    .quo_o(div_quo)
  );

  always_comb begin
    port_ok = (link.cmd_port == PORT_TENTH) ||
              (link.cmd_port == PORT_COARSE);
    if (link.cmd_port == PORT_TENTH) begin
      freq_ok = (link.cmd_freq >= FREQ_TENTH_MIN) &&
                (link.cmd_freq <= FREQ_TENTH_MAX);
    end else begin
      freq_ok = (link.cmd_freq >= FREQ_COARSE_MIN) &&
                (link.cmd_freq <= FREQ_COARSE_MAX) && !link.cmd_freq[0];
    end
    duty_ok = link.cmd_duty <= DUTY_MAX;
    any_err = !port_ok || (!link.cmd_stop && (!freq_ok || !duty_ok)) ||
              link.home_seek_active ||
              (link.cmd_from_irq && link.cyclic_busy);
  end

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    div_start = 1'b0;
    div_num = '0;
    div_den = 32'd1;
    div_done = 1'b0;
    // period = clk*unit/freq, high = period*duty/1000
    if (st_reg.state == ST_DIV_PER) begin
      div_num = st_reg.coarse ? 48'(UNIT_CYC) : 48'(TENTH_CYC);
      div_den = {16'h0, st_reg.freq};
    end else begin
      div_num = 48'(st_reg.period) * 48'(st_reg.duty);
      div_den = 32'(DUTY_MAX);
    end
    unique case (st_reg.state)
      ST_IDLE: begin
        st_next.out = 1'b0;
        st_next.kick = 1'b0;
      end
      ST_DIV_PER: begin
        div_start = !div_busy && !st_reg.pend;
        if (div_start) begin
          st_next.pend = 1'b1;
        end else if (st_reg.pend && !div_busy) begin
          st_next.pend = 1'b0;
          st_next.period = (div_quo == '0) ? 32'd1 : div_quo;
          st_next.state = ST_DIV_HIGH;
        end
      end
      ST_DIV_HIGH, ST_RUN: begin
        if (st_reg.state == ST_DIV_HIGH || st_reg.kick || st_reg.pend) begin
          div_start = !div_busy && !st_reg.pend;
          if (div_start) begin
            st_next.pend = 1'b1;
            st_next.kick = 1'b0;
          end else if (st_reg.pend && !div_busy) begin
            st_next.pend = 1'b0;
            div_done = 1'b1;
            st_next.high_pend = div_quo;
          end
        end
        if (st_reg.state == ST_DIV_HIGH && div_done) begin
          st_next.high = div_quo;
          st_next.cnt = '0;
          st_next.state = ST_RUN;
          st_next.done = 1'b1;
        end
        if (st_reg.state == ST_RUN) begin
          // high for first part of period
          // 0% low, 100% high through compare
          st_next.out = st_reg.cnt < st_reg.high;
          if (st_reg.cnt >= st_reg.period - 32'd1) begin
            st_next.cnt = '0;
            st_next.high = st_reg.high_pend;
          end else begin
            st_next.cnt = st_reg.cnt + 32'd1;
          end
          if (div_done) begin
            st_next.done = 1'b1;
          end
        end
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
    if (link.cmd_valid && (any_err || !st_reg.pend)) begin
      st_next.err = any_err;
      if (!any_err && link.cmd_stop) begin
        st_next.state = ST_IDLE;
        st_next.out = 1'b0;
        st_next.done = 1'b1;
      end else if (!any_err) begin
        st_next.duty = link.cmd_duty;
        if (st_reg.state == ST_RUN) begin
          st_next.kick = 1'b1;
        end else begin
          st_next.coarse = link.cmd_port == PORT_COARSE;
          st_next.freq = link.cmd_freq;
          st_next.state = ST_DIV_PER;
        end
      end else begin
        st_next.done = 1'b1;
      end
    end
    if (!link.run_mode) begin
      st_next.state = ST_IDLE;
      st_next.out = 1'b0;
      st_next.pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '{state: ST_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.cmd_done = st_reg.done;
  assign link.command_error_flag = st_reg.err;
  assign link.running = st_reg.state == ST_RUN;
  assign pwm_o = st_reg.out && (st_reg.state == ST_RUN);
endmodule : dpo_output

// File: rtl/dpo_host.sv
// controller end: Avalon-MM slave registers issuing one-cycle commands
module dpo_host
  import dpo_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // interrupt
  output logic irq_o,
  // link to device
  dpo_if.host link
);
  typedef struct packed {
    logic [15:0] port;
    logic [15:0] freq;
    logic [15:0] duty;
    logic valid;
    logic stop;
    logic from_irq;
    logic run;
    logic cyc_busy;
    logic home;
    logic [1:0] ev;
    logic [1:0] mask;
    logic ack;
    logic [31:0] rdata;
  } dpo_host_s;
  dpo_host_s st_reg, st_next;
  logic [1:0] ev_set;

  always_comb begin
    st_next = st_reg;
    st_next.valid = 1'b0;
    st_next.stop = 1'b0;
    st_next.ack = 1'b0;
    ev_set = '0;
    ev_set[EV_DONE_BIT] = link.cmd_done;
    ev_set[EV_ERR_BIT] = link.cmd_done && link.command_error_flag;
    // one-cycle-wait answer: ack the cycle after request
    if ((avs_read_i || avs_write_i) && !st_reg.ack) begin
      st_next.ack = 1'b1;
      if (avs_write_i) begin
        unique case (avs_address_i)
          REG_CMD_PORT: st_next.port = avs_writedata_i[15:0];
          REG_CMD_FREQ: st_next.freq = avs_writedata_i[15:0];
          REG_CMD_DUTY: st_next.duty = avs_writedata_i[15:0];
          REG_CTRL: begin
            st_next.valid = avs_writedata_i[CTRL_GO_BIT] ||
                            avs_writedata_i[CTRL_STOP_BIT];
            st_next.stop = avs_writedata_i[CTRL_STOP_BIT];
            st_next.run = avs_writedata_i[CTRL_RUN_BIT];
            st_next.from_irq = avs_writedata_i[CTRL_IRQ_BIT];
            st_next.home = avs_writedata_i[CTRL_HOME_BIT];
            // interrupt mask rides in the control word
            st_next.mask = avs_writedata_i[CTRL_MASK_LSB +: 2];
          end
          default: ;
        endcase
      end else begin
        unique case (avs_address_i)
          REG_STATUS: st_next.rdata = {29'h0, st_reg.run,
                                       link.running,
                                       link.command_error_flag};
          REG_EVENT: st_next.rdata = {30'h0, st_reg.ev};
          REG_MASK: st_next.rdata = {30'h0, st_reg.mask};
          default: st_next.rdata = 32'h0;
        endcase
        // read of events clears, new event wins
        if (avs_address_i == REG_EVENT) begin
          st_next.ev = '0;
        end
      end
    end
    st_next.ev = st_next.ev | ev_set;
    // cyclic context busy while a non-irq command is in flight
    if (st_next.valid && !st_next.from_irq) begin
      st_next.cyc_busy = 1'b1;
    end else if (link.cmd_done) begin
      st_next.cyc_busy = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_reg.ack;
  assign avs_readdata_o = st_reg.rdata;
  assign irq_o = |(st_reg.ev & st_reg.mask);
  assign link.cmd_valid = st_reg.valid;
  assign link.cmd_stop = st_reg.stop;
  assign link.cmd_from_irq = st_reg.from_irq;
  assign link.cmd_port = st_reg.port;
  assign link.cmd_freq = st_reg.stop ? CTRL_STOP : st_reg.freq;
  assign link.cmd_duty = st_reg.duty;
  assign link.run_mode = st_reg.run;
  assign link.cyclic_busy = st_reg.cyc_busy && st_reg.from_irq;
  assign link.home_seek_active = st_reg.home;
endmodule : dpo_host

// File: bench/dpo_chk.sv
module dpo_chk
  import dpo_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // command side
  input wire logic cmd_valid,
  input wire logic cmd_stop,
  input wire logic cmd_from_irq,
  input wire logic [15:0] cmd_port,
  input wire logic [15:0] cmd_freq,
  input wire logic [15:0] cmd_duty,
  input wire logic run_mode,
  input wire logic cyclic_busy,
  input wire logic home_seek_active,
  // device answers
  input wire logic cmd_done,
  input wire logic command_error_flag,
  input wire logic running,
  input wire logic pwm_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic go;
  logic port_ok;
  assign go = cmd_valid && !cmd_stop;
  assign port_ok = cmd_port == PORT_TENTH || cmd_port == PORT_COARSE;

  port_err_a: assert property (go && !port_ok |=> command_error_flag)
    else $error("bad port not flagged");
  tenth_err_a: assert property (go && cmd_port == PORT_TENTH &&
    cmd_freq < FREQ_TENTH_MIN |=> command_error_flag)
    else $error("low tenth frequency not flagged");
  coarse_err_a: assert property (go && cmd_port == PORT_COARSE &&
    (cmd_freq < FREQ_COARSE_MIN || cmd_freq > FREQ_COARSE_MAX || cmd_freq[0])
    |=> command_error_flag) else $error("coarse frequency not flagged");
  duty_err_a: assert property (go && cmd_duty > DUTY_MAX |=>
    command_error_flag) else $error("duty range not flagged");
  home_err_a: assert property (go && home_seek_active |=>
    command_error_flag) else $error("home seek clash not flagged");
  irq_err_a: assert property (go && cmd_from_irq && cyclic_busy |=>
    command_error_flag) else $error("context clash not flagged");
  stop_halt_a: assert property (cmd_valid && cmd_stop && port_ok &&
    !home_seek_active && !(cmd_from_irq && cyclic_busy)
    |-> ##[1:3] !running) else $error("stop did not halt output");
  clean_cmd_a: assert property (go && cmd_port == PORT_COARSE &&
    cmd_freq >= FREQ_COARSE_MIN && cmd_freq <= FREQ_COARSE_MAX &&
    !cmd_freq[0] && cmd_duty <= DUTY_MAX && !home_seek_active &&
    !(cmd_from_irq && cyclic_busy) |=> !command_error_flag)
    else $error("clean command left error flag set");
  run_exit_a: assert property ($fell(run_mode) |-> ##[1:3] !running)
    else $error("leaving run mode did not halt output");
  idle_low_a: assert property (!running [*3] |-> !pwm_o)
    else $error("output high while stopped");

  cover property ($rose(running));
  cover property (go ##1 command_error_flag);
  cover property ($fell(running));
  cover property (go && cmd_from_irq && cyclic_busy);
endmodule : dpo_chk

// File: bench/duty_pulse_output_control_test.sv
module duty_pulse_output_control_test
  import dpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i;
  logic reset_i;
  logic [3:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic irq_o;
  logic pwm_o;
  int miscompares = 0;
  int checks_done = 0;
  bit m_run;
  longint m_per;
  longint m_hi;
  logic [31:0] q;
  logic [15:0] f;
  logic [15:0] d;
  logic [47:0] errq[$] = '{{16'h1200, 16'h0100, 16'h01F4},
    {PORT_TENTH, 16'h0013, 16'h01F4}, {PORT_COARSE, 16'h0001, 16'h01F4},
    {PORT_COARSE, 16'h7D02, 16'h01F4}, {PORT_COARSE, 16'h0101, 16'h01F4},
    {PORT_COARSE, 16'h0100, 16'h03E9}};

  dpo_if link_if ();
  dpo_host u_dpo_host (.clk_i(clk_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o), .link(link_if.host));
  dpo_output u_dpo_output (.clk_i(clk_i), .reset_i(reset_i),
    .link(link_if.device), .pwm_o(pwm_o));
  dpo_chk u_dpo_chk (.clk_i(clk_i), .reset_i(reset_i),
    .cmd_valid(link_if.cmd_valid), .cmd_stop(link_if.cmd_stop),
    .cmd_from_irq(link_if.cmd_from_irq), .cmd_port(link_if.cmd_port),
    .cmd_freq(link_if.cmd_freq), .cmd_duty(link_if.cmd_duty),
    .run_mode(link_if.run_mode), .cyclic_busy(link_if.cyclic_busy),
    .home_seek_active(link_if.home_seek_active),
    .cmd_done(link_if.cmd_done),
    .command_error_flag(link_if.command_error_flag),
    .running(link_if.running), .pwm_o(pwm_o));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one avalon cycle; waitrequest and readdata sampled at rising edges
  task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] v,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    r = avs_readdata_o;
    if (n >= 64) miscompares++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic measure(output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    @(negedge clk_i);
    while (pwm_o !== 1'b0 && n < 20000) begin @(negedge clk_i); n++; end
    while (pwm_o !== 1'b1 && n < 20000) begin @(negedge clk_i); n++; end
    while (pwm_o === 1'b1 && n < 20000) begin
      @(negedge clk_i);
      hi++;
      n++;
    end
    per = hi;
    while (pwm_o === 1'b0 && n < 20000) begin
      @(negedge clk_i);
      per++;
      n++;
    end
  endtask : measure

  task automatic flat(input logic lv);
    int bad;
    bad = 0;
    repeat (1300) @(negedge clk_i);
    repeat (1300) begin
      @(negedge clk_i);
      if (pwm_o !== lv) bad++;
    end
    chk(32'(bad), 32'h0);
  endtask : flat

  task automatic issue(input logic [15:0] p, input logic [15:0] fr,
                       input logic [15:0] du, input logic [31:0] ex);
    int n;
    int hi;
    int per;
    bit e;
    e = !(p == PORT_TENTH || p == PORT_COARSE) || du > DUTY_MAX ||
      ex[CTRL_HOME_BIT] || (p == PORT_TENTH && fr < FREQ_TENTH_MIN) ||
      (p == PORT_COARSE && (fr < FREQ_COARSE_MIN || fr > FREQ_COARSE_MAX ||
      fr[0]));
    if (!e) begin
      if (!m_run) begin
        m_per = (p == PORT_TENTH) ? (TENTH_CYC + fr / 2) / fr :
          (UNIT_CYC + fr / 2) / fr;
        m_run = 1'b1;
      end
      m_hi = (m_per * du + 500) / 1000;
    end
    bus(1'b1, REG_CMD_PORT, {16'h0000, p}, q);
    bus(1'b1, REG_CMD_FREQ, {16'h0000, fr}, q);
    bus(1'b1, REG_CMD_DUTY, {16'h0000, du}, q);
    bus(1'b1, REG_CTRL, 32'h4 | ex, q);
    bus(1'b1, REG_CTRL, 32'h5 | ex, q);
    repeat (150) @(posedge clk_i);
    chk(32'(irq_o), 32'(|({1'b1, e} & ex[CTRL_MASK_LSB +: 2])));
    n = 0;
    do begin
      bus(1'b0, REG_EVENT, 32'h0, q);
      n++;
    end while (q[1:0] === 2'b00 && n < 50);
    chk(32'(q[1:0]), {30'h0, 1'b1, e});
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(32'(q[2:0]), {29'h0, 1'b1, m_run, e});
    chk(32'(irq_o), 32'h0);
    if (m_run && du != 16'h0000 && du < DUTY_MAX) begin
      measure(hi, per);
      chk(32'(per), 32'(m_per));
      chk(32'(hi), 32'(m_hi));
    end
  endtask : issue

  task automatic halt(input logic [31:0] v);
    m_run = 1'b0;
    bus(1'b1, REG_CTRL, v, q);
    repeat (4) @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(32'(q[1]), 32'h0);
    bus(1'b0, REG_EVENT, 32'h0, q);
    chk(32'(q[1:0]), {30'h0, v[CTRL_STOP_BIT], 1'b0});
    flat(1'b0);
  endtask : halt

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (80000) @(posedge clk_i);
    miscompares++;
    summarize();
  end

  initial begin
    reset_i = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    void'($urandom(17));
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, REG_EVENT, 32'h0, q);
    chk(q, {30'h0, EV_RESET});
    bus(1'b0, REG_MASK, 32'h0, q);
    chk(q, {30'h0, MASK_RESET});
    bus(1'b0, 4'h1, 32'h0, q);
    chk(q, 32'h0);
    chk(32'(pwm_o), 32'h0);
    bus(1'b1, REG_CTRL, 32'h4, q);
    foreach (errq[i]) issue(errq[i][47:32], errq[i][31:16], errq[i][15:0], 0);
    issue(PORT_COARSE, 16'h7D00, 16'h01F4, 32'h110);
    issue(PORT_COARSE, 16'h7D00, 16'h01F4, 32'h200);
    issue(PORT_COARSE, 16'h0100, 16'h00C8, 32'h0);
    // cyclic duty call, then an interrupt-context call while it is busy
    bus(1'b1, REG_CTRL, 32'h5, q);
    bus(1'b1, REG_CTRL, 32'hD, q);
    repeat (150) @(posedge clk_i);
    bus(1'b0, REG_EVENT, 32'h0, q);
    chk(32'(q[1:0]), 32'h3);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(32'(q[2:0]), 32'h7);
    issue(PORT_COARSE, 16'h0100, 16'h0000, 32'h0);
    flat(1'b0);
    issue(PORT_COARSE, 16'h0100, DUTY_MAX, 32'h0);
    flat(1'b1);
    halt(32'h6);
    issue(PORT_TENTH, FREQ_TENTH_MAX, 16'h00FA, 32'h0);
    halt(32'h0);
    bus(1'b1, REG_CTRL, 32'h4, q);
    repeat (3) begin
      f = 16'(16000 + 2 * ($urandom % 8001));
      d = 16'(10 + $urandom % 981);
      issue(PORT_COARSE, f, d, 32'h0);
      halt(32'h6);
    end
    summarize();
  end
endmodule : duty_pulse_output_control_test
